// ==== rtl/vcl_pkg.sv ====
// Shared constants and types of the common-electrode level registers
package vcl_pkg;

   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_LEVEL_READ = 8'h81;
   localparam logic [7:0] CMD_DC_SET = 8'h82;

   // ----------------------------------------
   // Field layout and reset values
   // ----------------------------------------
   localparam int SOURCE_SEL_BIT = 7;
   localparam int CODE_MSB = 6;
   localparam int CODE_W = 7;
   localparam logic [7:0] DC_SET_RESET = 8'h00;
   localparam logic [6:0] READBACK_RESET = 7'h00;
   localparam logic [6:0] LEVEL_CODE_MAX = 7'h50;

   // ----------------------------------------
   // Serial framing
   // ----------------------------------------
   localparam int SYNC_STAGES = 3;
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic sdi;
      logic dc;
   } vcl_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_READ = 2'b10
   } vcl_state_t;

endpackage

// ==== rtl/vcl_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module vcl_pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous pins in, filtered pins out
   input wire vcl_pkg::vcl_pins_t pins_in,
   output vcl_pkg::vcl_pins_t pins_out
);

   localparam int W = $bits(vcl_pkg::vcl_pins_t);
   localparam logic [W-1:0] IDLE_PINS = {1'b1, {(W-1){1'b0}}};

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q[i] <= IDLE_PINS[i];
               s2_q[i] <= IDLE_PINS[i];
               s3_q[i] <= IDLE_PINS[i];
               out_q[i] <= IDLE_PINS[i];
            end else begin
               s1_q[i] <= pins_in[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               // A change is taken only when the last two stages agree
               if (s2_q[i] == s3_q[i]) begin
                  out_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate

   assign pins_out = out_q;

endmodule

// ==== rtl/vcl_level_regs.sv ====
// Common-electrode level registers behind the serial command port
//
// Operation
// - Command 81h returns seven-bit level code, reset zero.
// - Command 82h takes one byte: select, code.
// - Drive code steps 0.05V, saturates at 1010000.
// - Bit seven picks measured or written level.
// - Probe option zero puts measurement on readback.
// - Measurement runs only while enable bit set.
`timescale 1ns/1ps
module vcl_level_regs (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Serial command port
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic SDIO_IN,
   output logic SDIO_OUT,
   output logic SDIO_OE_N,
   input wire logic DC,
   // Measurement control and result
   input wire logic AUTO_MEASURE_ENABLE,
   input wire logic MEASURE_PROBE_OPTION,
   input wire logic MEAS_DONE,
   input wire logic [6:0] MEAS_CODE,
   output logic MEASURE_RUN,
   // Level outputs
   output logic [6:0] LEVEL_CODE,
   output logic LEVEL_SOURCE_SELECT
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [6:0] clamp_code(input logic [6:0] code);
      clamp_code = (code > vcl_pkg::LEVEL_CODE_MAX) ? vcl_pkg::LEVEL_CODE_MAX : code;
   endfunction

   // Maps a command byte to the state that handles its parameter
   function automatic vcl_pkg::vcl_state_t decode_cmd(input logic [7:0] code);
      case (code)
         vcl_pkg::CMD_LEVEL_READ: decode_cmd = vcl_pkg::ST_READ;
         vcl_pkg::CMD_DC_SET: decode_cmd = vcl_pkg::ST_WRITE;
         default: decode_cmd = vcl_pkg::ST_IDLE;
      endcase
   endfunction

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   // A pin edge that holds for two clocks reaches the decoder four clocks late, so SCLK phases must be longer
   vcl_pkg::vcl_pins_t pins_raw;
   vcl_pkg::vcl_pins_t pins;

   assign pins_raw = '{cs_n: CS_N, sclk: SCLK, sdi: SDIO_IN, dc: DC};

   vcl_pin_sync u_sync (
      .clk(CLK),
      .rst_n(RSTN),
      .pins_in(pins_raw),
      .pins_out(pins)
   );

   // ----------------------------------------
   // Serial byte assembly
   // ----------------------------------------
   logic sclk_prev_q;
   logic [2:0] bit_cnt_q;
   logic [2:0] bit_cnt_d;
   logic [7:0] rx_q;
   logic [7:0] rx_d;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   vcl_pkg::vcl_state_t state_q;
   vcl_pkg::vcl_state_t state_d;
   logic [7:0] dc_set_q;
   logic [7:0] dc_set_d;
   logic [6:0] readback_q;
   logic [6:0] readback_d;
   logic sdo_q;
   logic sdo_d;
   logic oe_n_q;
   logic oe_n_d;
   logic [6:0] level_q;
   logic sel_q;
   logic run_q;

   wire active = !pins.cs_n;
   wire rise = active && pins.sclk && !sclk_prev_q;
   wire fall = active && !pins.sclk && sclk_prev_q;
   wire [7:0] byte_in = {rx_q[6:0], pins.sdi};
   wire byte_done = rise && (bit_cnt_q == vcl_pkg::LAST_BIT);
   wire cmd_done = byte_done && !pins.dc;
   wire data_done = byte_done && pins.dc;
   vcl_pkg::vcl_state_t cmd_state;
   assign cmd_state = decode_cmd(byte_in);

   assign bit_cnt_d = !active ? 3'h0 : (rise ? bit_cnt_q + 3'h1 : bit_cnt_q);
   assign rx_d = rise ? byte_in : rx_q;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         vcl_pkg::ST_IDLE: begin
            state_d = vcl_pkg::ST_IDLE;
         end
         vcl_pkg::ST_WRITE: begin
            if (data_done) begin
               state_d = vcl_pkg::ST_IDLE;
            end
         end
         vcl_pkg::ST_READ: begin
            if (byte_done) begin
               state_d = vcl_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = vcl_pkg::ST_IDLE;
         end
      endcase
      // A command byte always restarts decoding
      if (cmd_done) begin
         state_d = cmd_state;
      end
   end

   wire dc_write = data_done && (state_q == vcl_pkg::ST_WRITE);
   wire read_start = cmd_done && (cmd_state == vcl_pkg::ST_READ);

   assign dc_set_d = dc_write ? byte_in : dc_set_q;

   // ----------------------------------------
   // Readback path
   // ----------------------------------------
   wire meas_take = MEAS_DONE && AUTO_MEASURE_ENABLE && !MEASURE_PROBE_OPTION;
   assign readback_d = meas_take ? MEAS_CODE : readback_q;

   // The read byte is frozen when the command ends, so a late measurement cannot tear it
   wire reading = (state_q == vcl_pkg::ST_READ);
   wire shift_out = fall && reading;
   wire release_out = fall && !reading;
   assign tx_d = read_start ? {1'b0, readback_q} : (shift_out ? {tx_q[6:0], 1'b0} : tx_q);
   assign sdo_d = shift_out ? tx_q[7] : sdo_q;
   assign oe_n_d = !active ? 1'b1 : (shift_out ? 1'b0 : (release_out ? 1'b1 : oe_n_q));

   // ----------------------------------------
   // Level selection
   // ----------------------------------------
   // Both sources are clamped, so an over-range measurement saturates like a written code
   wire sel_d = dc_set_q[vcl_pkg::SOURCE_SEL_BIT];
   wire [6:0] written_code = dc_set_q[vcl_pkg::CODE_MSB:0];
   wire [6:0] chosen_code = sel_d ? written_code : readback_q;
   wire [6:0] level_d = clamp_code(chosen_code);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_prev_q <= 1'b0;
         bit_cnt_q <= 3'h0;
         rx_q <= 8'h00;
      end else begin
         sclk_prev_q <= pins.sclk;
         bit_cnt_q <= bit_cnt_d;
         rx_q <= rx_d;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tx_q <= 8'h00;
         state_q <= vcl_pkg::ST_IDLE;
      end else begin
         tx_q <= tx_d;
         state_q <= state_d;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         dc_set_q <= vcl_pkg::DC_SET_RESET;
         readback_q <= vcl_pkg::READBACK_RESET;
         sdo_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         dc_set_q <= dc_set_d;
         readback_q <= readback_d;
         sdo_q <= sdo_d;
         oe_n_q <= oe_n_d;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         level_q <= vcl_pkg::READBACK_RESET;
         sel_q <= vcl_pkg::DC_SET_RESET[vcl_pkg::SOURCE_SEL_BIT];
      end else begin
         level_q <= level_d;
         sel_q <= sel_d;
      end
   end

   // ----------------------------------------
   // Measurement enable
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         run_q <= 1'b0;
      end else begin
         run_q <= AUTO_MEASURE_ENABLE;
      end
   end

   assign SDIO_OUT = sdo_q;
   assign SDIO_OE_N = oe_n_q;
   assign LEVEL_CODE = level_q;
   assign LEVEL_SOURCE_SELECT = sel_q;
   assign MEASURE_RUN = run_q;

endmodule

// ==== testbench/vcl_level_regs_chk.sv ====
// Port checks of the level registers
`timescale 1ns/1ps
module vcl_level_regs_chk (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Serial port
   input wire logic CS_N,
   input wire logic SDIO_OUT,
   input wire logic SDIO_OE_N,
   // Measurement
   input wire logic AUTO_MEASURE_ENABLE,
   input wire logic MEASURE_PROBE_OPTION,
   input wire logic MEAS_DONE,
   input wire logic [6:0] MEAS_CODE,
   input wire logic MEASURE_RUN,
   // Levels
   input wire logic [6:0] LEVEL_CODE,
   input wire logic LEVEL_SOURCE_SELECT
);
   logic [6:0] exp_q;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) exp_q <= 7'h00;
      else if (MEAS_DONE) exp_q <= (MEAS_CODE > 7'h50) ? 7'h50 : MEAS_CODE;
   end
   sequence s_taken;
      MEAS_DONE && AUTO_MEASURE_ENABLE && !MEASURE_PROBE_OPTION && !LEVEL_SOURCE_SELECT;
   endsequence
   sequence s_skipped;
      MEAS_DONE && !(AUTO_MEASURE_ENABLE && !MEASURE_PROBE_OPTION) && !LEVEL_SOURCE_SELECT;
   endsequence
   chk_reset_values: assert property ($rose(RSTN) |-> LEVEL_CODE == 7'h00 && !LEVEL_SOURCE_SELECT)
      else $error("level not clear after reset");
   chk_level_clamp: assert property (LEVEL_CODE <= 7'h50)
      else $error("level above clamp");
   chk_run_rise: assert property ($rose(AUTO_MEASURE_ENABLE) |=> MEASURE_RUN)
      else $error("run not set");
   chk_run_fall: assert property ($fell(AUTO_MEASURE_ENABLE) |=> !MEASURE_RUN)
      else $error("run not cleared");
   chk_meas_load: assert property (s_taken |-> ##[1:3] LEVEL_CODE == exp_q)
      else $error("measured code not applied");
   chk_meas_skip: assert property (s_skipped |=> $stable(LEVEL_CODE)[*3])
      else $error("ignored code applied");
   chk_oe_idle: assert property (CS_N[*8] |-> SDIO_OE_N)
      else $error("drives while deselected");
   chk_read_msb: assert property ($fell(SDIO_OE_N) |-> !SDIO_OUT)
      else $error("read bit7 not zero");
endmodule
bind vcl_level_regs vcl_level_regs_chk vcl_level_regs_chk_inst (.CLK(CLK), .RSTN(RSTN), .CS_N(CS_N),
   .SDIO_OUT(SDIO_OUT), .SDIO_OE_N(SDIO_OE_N), .AUTO_MEASURE_ENABLE(AUTO_MEASURE_ENABLE),
   .MEASURE_PROBE_OPTION(MEASURE_PROBE_OPTION), .MEAS_DONE(MEAS_DONE), .MEAS_CODE(MEAS_CODE),
   .MEASURE_RUN(MEASURE_RUN), .LEVEL_CODE(LEVEL_CODE), .LEVEL_SOURCE_SELECT(LEVEL_SOURCE_SELECT));

// ==== testbench/vcl_host_model.sv ====
// Host serial master model
`timescale 1ns/1ps
module vcl_host_model (
   // Clock
   input wire logic clk,
   // Wire level and pins
   input wire logic sdio,
   output vcl_pkg::vcl_pins_t pins
);
   initial pins = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0, dc: 1'b0};
   task automatic half();
      repeat (10) @(posedge clk);
   endtask
   // Sample the wire at the rise
   task automatic bit_cycle(input logic d, input logic dc, output logic got);
      pins.sclk <= 1'b0;
      pins.sdi <= d;
      pins.dc <= dc;
      half();
      pins.sclk <= 1'b1;
      got = sdio;
      half();
   endtask
   // Released line toggles while the device answers
   task automatic frame(input logic [7:0] cmd, input logic rd, input logic [7:0] wr, output logic [7:0] got);
      logic x;
      pins.cs_n <= 1'b0;
      half();
      for (int i = 7; i >= 0; i--) bit_cycle(cmd[i], 1'b0, x);
      for (int i = 7; i >= 0; i--) bit_cycle(rd ? ~pins.sdi : wr[i], 1'b1, got[i]);
      pins.sclk <= 1'b0;
      half();
      pins.cs_n <= 1'b1;
      half();
      half();
   endtask
endmodule

// ==== testbench/tb_top.sv ====
// Bench for the level registers
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic en = 1'b0;
   logic probe = 1'b0;
   logic done = 1'b0;
   logic [6:0] mcode = 7'h00;
   logic [7:0] got;
   vcl_pkg::vcl_pins_t pins;
   logic sdo, oe_n, run, sel;
   logic [6:0] lvl;
   wire sdio;
   int err_count = 0;
   int n_checks = 0;
   always #5 clk = ~clk;
   assign sdio = oe_n ? pins.sdi : sdo;
   vcl_host_model vcl_host_model_inst (.clk(clk), .sdio(sdio), .pins(pins));
   vcl_level_regs vcl_level_regs_inst (.CLK(clk), .RSTN(rstn), .CS_N(pins.cs_n), .SCLK(pins.sclk),
      .SDIO_IN(sdio), .SDIO_OUT(sdo), .SDIO_OE_N(oe_n), .DC(pins.dc), .AUTO_MEASURE_ENABLE(en),
      .MEASURE_PROBE_OPTION(probe), .MEAS_DONE(done), .MEAS_CODE(mcode), .MEASURE_RUN(run),
      .LEVEL_CODE(lvl), .LEVEL_SOURCE_SELECT(sel));
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (err_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic meas(input logic [6:0] c, input logic [6:0] exp);
      done <= 1'b1;
      mcode <= c;
      @(posedge clk);
      done <= 1'b0;
      repeat (4) @(posedge clk);
      check("level", {1'b0, exp}, {1'b0, lvl});
   endtask
   task automatic rd_level(input logic [6:0] exp);
      vcl_host_model_inst.frame(vcl_pkg::CMD_LEVEL_READ, 1'b1, 8'h00, got);
      check("readback", {1'b0, exp}, got);
   endtask
   task automatic wr_set(input logic [7:0] v, input logic s, input logic [6:0] exp);
      vcl_host_model_inst.frame(vcl_pkg::CMD_DC_SET, 1'b0, v, got);
      check("select", {7'h00, s}, {7'h00, sel});
      check("level", {1'b0, exp}, {1'b0, lvl});
   endtask
   task automatic t_reset();
      check("select", 8'h00, {7'h00, sel});
      rd_level(7'h00);
   endtask
   task automatic t_measure();
      en <= 1'b1;
      repeat (2) @(posedge clk);
      check("run", 8'h01, {7'h00, run});
      meas(7'h23, 7'h23);
      rd_level(7'h23);
      meas(7'h7f, 7'h50);
      meas(7'h50, 7'h50);
   endtask
   task automatic t_ignored();
      en <= 1'b0;
      repeat (2) @(posedge clk);
      check("run", 8'h00, {7'h00, run});
      meas(7'h11, 7'h50);
      en <= 1'b1;
      probe <= 1'b1;
      @(posedge clk);
      meas(7'h11, 7'h50);
      probe <= 1'b0;
      rd_level(7'h50);
   endtask
   task automatic t_write();
      wr_set(8'ha5, 1'b1, 7'h25);
      meas(7'h11, 7'h25);
      wr_set(8'hd1, 1'b1, 7'h50);
      wr_set(8'h4f, 1'b0, 7'h11);
      rd_level(7'h11);
   endtask
   task automatic t_refused();
      vcl_host_model_inst.frame(8'h7e, 1'b0, 8'ha5, got);
      check("select", 8'h00, {7'h00, sel});
      check("level", 8'h11, {1'b0, lvl});
   endtask
   task automatic t_rereset();
      wr_set(8'h85, 1'b1, 7'h05);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      check("select", 8'h00, {7'h00, sel});
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      check("level", 8'h00, {1'b0, lvl});
      rd_level(7'h00);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
      t_measure();
      t_ignored();
      t_write();
      t_refused();
      t_rereset();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      complete_run();
   end
endmodule
